/* File: rtl/pcc_capture.sv */
// Notes on behaviour
// [R1] Captured entries sit in a FIFO of sixteen 32-bit words.
// [R2] A 24-bit timer counts freely and supplies each entry's timestamp.
// [R3] Each host data write pushes the byte joined with the current timestamp.
// [R4] Host reads of the data register return zero and leave the FIFO alone.
// [R5] A write into a full FIFO with no controller read beside it drops the oldest entry and sets overrun.
// [R6] Only the controller reads FIFO contents; the host has no read path.
// [R7] Host writes through its own port; controller reads and controls separately.
// [R8] Host data port is byte wide; wider writes must not be issued.
// [R9] Each controller read returns and removes the oldest entry, in order.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defs.svh"

module pcc_capture
	import pcc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [`PCC_CODE_W-1:0] HOST_WDATA,
	output logic [`PCC_CODE_W-1:0] HOST_RDATA,
	input wire logic EC_RD,
	input wire logic EC_OVR_CLR,
	output pcc_word_t EC_RDATA,
	output logic EC_RVALID,
	output logic EC_NOT_EMPTY,
	output logic EC_OVERRUN,
	output pcc_cnt_t EC_COUNT
);
	// ----------------------------------------
	// Storage and state
	// ----------------------------------------
	pcc_word_t mem_r [`PCC_DEPTH];
	pcc_word_t mem_nxt [`PCC_DEPTH];
	pcc_ptr_t wr_ptr_r, wr_ptr_nxt;
	pcc_ptr_t rd_ptr_r, rd_ptr_nxt;
	pcc_cnt_t count_r, count_nxt;
	logic ovr_r, ovr_nxt;
	pcc_word_t rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [`PCC_CODE_W-1:0] hrdata_r, hrdata_nxt;
	logic ne_r, ne_nxt;
	pcc_ts_t stamp;
	pcc_word_t entry;
	logic full, empty, do_pop, drop;

	// Timestamp source.
	pcc_timer u_timer (
		.clk(CLK),
		.rst_b(RST_B),
		.stamp(stamp) // R2
	);

	// Entry is the host byte joined under the timestamp.
	assign entry = {stamp, HOST_WDATA}; // R3 R8
	assign full = (count_r == `PCC_CNT_W'(`PCC_DEPTH)); // R1
	assign empty = (count_r == `PCC_CNT_W'(0));
	assign do_pop = EC_RD && !empty; // R9
	assign drop = HOST_WR && full && !do_pop; // R5

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------

	// Computes pointers, count, overrun flag and read data.
	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		ovr_nxt = ovr_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		hrdata_nxt = '0; // R4 R6
		if (do_pop) begin
			rdata_nxt = mem_r[rd_ptr_r]; // R6 R9
			rvalid_nxt = 1'b1;
			rd_ptr_nxt = rd_ptr_r + `PCC_PTR_W'(1);
		end
		if (HOST_WR) begin
			wr_ptr_nxt = wr_ptr_r + `PCC_PTR_W'(1); // R3
		end
		if (drop) begin
			rd_ptr_nxt = rd_ptr_r + `PCC_PTR_W'(1); // R5
		end
		if (HOST_WR && !do_pop && !full) begin
			count_nxt = count_r + `PCC_CNT_W'(1);
		end else if (do_pop && !HOST_WR) begin
			count_nxt = count_r - `PCC_CNT_W'(1);
		end
		// The flag follows the next fill level so that it leaves a flip-flop.
		ne_nxt = (count_nxt != '0);
		// A clear in the same cycle as an overrun loses to the overrun.
		if (EC_OVR_CLR) begin
			ovr_nxt = 1'b0; // R7
		end
		if (drop) begin
			ovr_nxt = 1'b1; // R5
		end
	end

	// Writes the new entry into the slot under the write pointer.
	generate
		for (genvar i = 0; i < `PCC_DEPTH; i++) begin : g_slot
			always_comb begin
				mem_nxt[i] = mem_r[i];
				if (HOST_WR && wr_ptr_r == `PCC_PTR_W'(i)) begin
					mem_nxt[i] = entry; // R1 R3
				end
			end
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					mem_r[i] <= `PCC_WORD_RESET;
				end else begin
					mem_r[i] <= mem_nxt[i];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// State registers
	// ----------------------------------------

	// Registers FIFO control and controller-side outputs.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			ovr_r <= 1'b0;
			rdata_r <= `PCC_WORD_RESET;
			rvalid_r <= 1'b0;
			hrdata_r <= '0;
			ne_r <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
			ovr_r <= ovr_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			hrdata_r <= hrdata_nxt; // R4 R6
			ne_r <= ne_nxt;
		end
	end

	// Output drives, all straight from flip-flops.
	assign HOST_RDATA = hrdata_r;
	assign EC_RDATA = rdata_r;
	assign EC_RVALID = rvalid_r;
	assign EC_OVERRUN = ovr_r;
	assign EC_COUNT = count_r;
	assign EC_NOT_EMPTY = ne_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence host_push_s;
		HOST_WR && !EC_RD && !full;
	endsequence

	sequence pop_s;
		EC_RD && !empty && !HOST_WR;
	endsequence

	// A host write and a real pop in the same cycle.
	sequence both_ends_s;
		HOST_WR && EC_RD && !empty;
	endsequence

	// A controller read while nothing is stored.
	sequence empty_read_s;
		EC_RD && empty;
	endsequence

	fifo_depth_a: assert property (@(posedge CLK) disable iff (!RST_B)
		count_r <= `PCC_CNT_W'(`PCC_DEPTH)) // R1
		else $error("Fill level beyond depth.");

	push_counts_a: assert property (@(posedge CLK) disable iff (!RST_B)
		host_push_s |=> count_r == $past(count_r) + `PCC_CNT_W'(1)) // R3
		else $error("Host write did not add an entry.");

	entry_stamped_a: assert property (@(posedge CLK) disable iff (!RST_B)
		HOST_WR |=> mem_r[$past(wr_ptr_r)] == {$past(stamp), $past(HOST_WDATA)}) // R3
		else $error("Stored entry not byte plus timestamp.");

	host_read_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
		HOST_RD && !HOST_WR && !EC_RD |=> HOST_RDATA == '0 && count_r == $past(count_r)) // R4
		else $error("Host read returned data or changed FIFO.");

	overrun_drop_a: assert property (@(posedge CLK) disable iff (!RST_B)
		HOST_WR && full && !EC_RD |=> EC_OVERRUN && full
		&& rd_ptr_r == $past(rd_ptr_r) + `PCC_PTR_W'(1)) // R5
		else $error("Overrun did not drop oldest entry.");

	overrun_sticky_a: assert property (@(posedge CLK) disable iff (!RST_B)
		EC_OVERRUN && !EC_OVR_CLR |=> EC_OVERRUN) // R5
		else $error("Overrun flag cleared without request.");

	pop_oldest_a: assert property (@(posedge CLK) disable iff (!RST_B)
		EC_RD && !empty |=> EC_RVALID && EC_RDATA == $past(mem_r[rd_ptr_r])) // R9
		else $error("Controller read did not return oldest entry.");

	pop_removes_a: assert property (@(posedge CLK) disable iff (!RST_B)
		pop_s |=> count_r == $past(count_r) - `PCC_CNT_W'(1)) // R6 R9
		else $error("Controller read did not remove entry.");

	// A push beside a pop keeps the level and never counts as an overrun.
	push_pop_keep_a: assert property (@(posedge CLK) disable iff (!RST_B)
		both_ends_s |=> count_r == $past(count_r) && !$rose(EC_OVERRUN)) // R5 R9
		else $error("Push beside a pop changed level or overran.");

	// A read of an empty FIFO gives no data strobe and keeps the last word.
	empty_read_quiet_a: assert property (@(posedge CLK) disable iff (!RST_B)
		empty_read_s |=> !EC_RVALID && $stable(EC_RDATA)) // R9
		else $error("Read of empty FIFO returned data.");

	// A clear with no overrun beside it lowers the flag.
	overrun_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
		EC_OVR_CLR && !(HOST_WR && full && !EC_RD) |=> !EC_OVERRUN) // R7
		else $error("Overrun flag not cleared on request.");

	// The not-empty flag always agrees with the fill level.
	flag_matches_count_a: assert property (@(posedge CLK) disable iff (!RST_B)
		EC_NOT_EMPTY == (EC_COUNT != '0)) // R1
		else $error("Not-empty flag disagrees with fill level.");
endmodule

`default_nettype wire

/* File: rtl/pcc_defs.svh */
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// ----------------------------------------
// Capture block constants
// ----------------------------------------
`define PCC_WORD_W 32
`define PCC_DEPTH 16
`define PCC_PTR_W 4
`define PCC_CNT_W 5
`define PCC_TS_W 24
`define PCC_CODE_W 8
`define PCC_TS_RESET 24'h000000
`define PCC_WORD_RESET 32'h00000000
`define PCC_CODE_LSB 0
`define PCC_TS_LSB 8

`endif

/* File: rtl/pcc_pkg.sv */
`include "pcc_defs.svh"

package pcc_pkg;
	typedef logic [`PCC_WORD_W-1:0] pcc_word_t;
	typedef logic [`PCC_TS_W-1:0] pcc_ts_t;
	typedef logic [`PCC_PTR_W-1:0] pcc_ptr_t;
	typedef logic [`PCC_CNT_W-1:0] pcc_cnt_t;
endpackage

/* File: rtl/pcc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defs.svh"

module pcc_timer
	import pcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	output pcc_ts_t stamp
);
	pcc_ts_t cnt_r;
	pcc_ts_t cnt_nxt;

	// ----------------------------------------
	// Free-running timestamp counter
	// ----------------------------------------

	// The counter wraps silently; no software action is ever needed.
	always_comb begin
		cnt_nxt = cnt_r + `PCC_TS_W'(1); // R2
	end

	// Registers the counter.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= `PCC_TS_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign stamp = cnt_r;

	// Checks that the timer advances by one every cycle once a full cycle is out of reset.
	timer_counts_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> cnt_r == $past(cnt_r) + `PCC_TS_W'(1)) // R2
		else $error("Timer did not advance by one.");
endmodule

`default_nettype wire

/* File: verif/pcc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model
	import pcc_pkg::*;
(
	input wire logic clk,
	input wire pcc_ts_t tmr,
	output logic wr,
	output logic rd,
	output logic [7:0] wdata
);
	// The host bus starts idle.
	initial begin
		wr = 1'h0;
		rd = 1'h0;
		wdata = 8'h00;
	end
	// One byte per write strobe; the expected stored word is handed back.
	task automatic put(input logic [7:0] b, output pcc_word_t e);
		@(posedge clk);
		wr <= 1'h1;
		wdata <= b;
		@(negedge clk);
		e = {tmr, b};
		@(posedge clk);
		wr <= 1'h0;
		wdata <= ~b; // Released data shows the inverse of the last byte.
	endtask
	// A single read strobe of the data register.
	task automatic get();
		@(posedge clk);
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pcc_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, ec_rd = 1'h0, ec_clr = 1'h0;
	logic h_wr, h_rd, rvld, nempty, ovr;
	logic [7:0] h_wd, h_rdata;
	pcc_word_t ec_rdata, e;
	pcc_word_t q[$];
	pcc_cnt_t cnt;
	pcc_ts_t tmr;
	int bad_count = 0, checks_done = 0;
	// The clock toggles every half period.
	always #12.5 clk = ~clk;
	// Reference timer that follows the free-running stamp.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			tmr <= 24'h000000;
		else
			tmr <= tmr + 24'h000001;
	end
	pcc_host_model host (.clk(clk), .tmr(tmr), .wr(h_wr), .rd(h_rd), .wdata(h_wd));
	pcc_capture uut (.CLK(clk), .RST_B(rst_b), .HOST_WR(h_wr), .HOST_RD(h_rd),
		.HOST_WDATA(h_wd), .HOST_RDATA(h_rdata), .EC_RD(ec_rd), .EC_OVR_CLR(ec_clr),
		.EC_RDATA(ec_rdata), .EC_RVALID(rvld), .EC_NOT_EMPTY(nempty),
		.EC_OVERRUN(ovr), .EC_COUNT(cnt));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			bad_count++;
			$display("[ERR] %0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// A host write; the model queue drops its oldest word when full.
	task automatic push(input logic [7:0] b);
		host.put(b, e);
		if (q.size() == 16)
			void'(q.pop_front());
		q.push_back(e);
	endtask
	// A controller pop with the oldest expected word compared.
	task automatic pop();
		@(posedge clk);
		ec_rd <= 1'h1;
		@(posedge clk);
		ec_rd <= 1'h0;
		#1 chk(rvld, 32'h1);
		chk(ec_rdata, q.pop_front());
	endtask
	task automatic t_order();
		for (int i = 0; i < 3; i++)
			push(8'hA0 + 8'(i));
		#1 chk(cnt, 32'h3);
		chk(nempty, 32'h1);
		// A push and a pop in one cycle keep the level.
		fork
			push(8'hA3);
			pop();
		join
		#1 chk(cnt, 32'h3);
		for (int i = 0; i < 3; i++)
			pop();
		chk(cnt, 32'h0);
	endtask
	task automatic t_hostrd();
		push(8'h5A);
		host.get();
		#1 chk(h_rdata, 32'h0);
		chk(cnt, 32'h1);
		pop();
	endtask
	task automatic t_overrun();
		for (int i = 0; i < 17; i++)
			push(8'(i));
		#1 chk(cnt, 32'h10);
		chk(ovr, 32'h1);
		// A clear in the cycle of a further overrun loses to it.
		fork
			push(8'hEE);
			begin
				@(posedge clk);
				ec_clr <= 1'h1;
				@(posedge clk);
				ec_clr <= 1'h0;
			end
		join
		#1 chk(ovr, 32'h1);
		for (int i = 0; i < 16; i++)
			pop();
		@(posedge clk);
		ec_rd <= 1'h1;
		@(posedge clk);
		ec_rd <= 1'h0;
		ec_clr <= 1'h1;
		#1 chk(rvld, 32'h0);
		@(posedge clk);
		ec_clr <= 1'h0;
		#1 chk(ovr, 32'h0);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence after ten reset cycles.
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		t_order();
		t_hostrd();
		t_overrun();
		end_of_test();
	end
	// Watchdog against a hang.
	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
